// ### rtl/jio_top.sv
// Execution of jump, increment, increment-skip and two OR operations.
// Assumes the fetch unit presents the instruction at program_counter and
// the register file returns the addressed register on reg_rdata at once.
`timescale 1ns/1ps
module jio_top
    import jio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire jio_op_type instr_op,
    input wire logic [10:0] instr_literal,
    input wire logic [6:0] instr_reg_addr,
    input wire logic instr_dest,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] upper_jump_latch,
    output logic instr_ready,
    output logic [12:0] program_counter,
    output logic [7:0] accumulator,
    output logic zero_flag,
    output logic reg_wr_en,
    output logic [6:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    output logic skip_nop
);
    // ==================================================================
    // State
    // ==================================================================
    // All state lives in one record so reset and update stay in step.
    typedef struct packed {
        jio_state_type state; // Run, or dead cycle of a two-cycle op.
        logic ready; // Accepting a new instruction.
        logic [12:0] pc; // Program counter.
        logic [7:0] acc; // Accumulator.
        logic zero; // Zero flag.
        logic wr_en; // Register file write strobe.
        logic [6:0] wr_addr; // Register file write address.
        logic [7:0] wr_data; // Register file write data.
        logic skipped; // Dead cycle stands in for a skipped op.
    } jio_core_type;

    jio_core_type state_ff; // Registered state.
    jio_core_type nxt_state; // Next state.
    logic take; // Instruction accepted this cycle.
    logic has_dest; // Operation honours the destination bit.
    logic upd_zero; // Operation updates the zero flag.

    jio_alu_if alu_bus ();

    // ==================================================================
    // Data path
    // ==================================================================
    assign alu_bus.op = instr_op;
    assign alu_bus.acc = state_ff.acc;
    assign alu_bus.opnd = reg_rdata;
    assign alu_bus.lit = instr_literal[7:0];

    jio_alu u_alu (
        .bus (alu_bus)
    );

    assign take = instr_valid && state_ff.ready;

    // ==================================================================
    // Operation classes
    // ==================================================================
    // The jump and the literal OR have no destination choice; the skip
    // form is the only register op that leaves the flag alone.
    always_comb begin
        has_dest = 1'b0;
        upd_zero = 1'b0;
        case (instr_op)
            JIO_OP_INCREMENT_SKIP_ON_NULL: begin
                has_dest = 1'b1;
            end
            JIO_OP_INCREMENT_REGISTER,
            JIO_OP_OR_ACCUMULATOR_WITH_REGISTER: begin
                has_dest = 1'b1; // RULE4
                upd_zero = 1'b1; // RULE6 RULE8
            end
            JIO_OP_OR_LITERAL_INTO_ACCUMULATOR: begin
                upd_zero = 1'b1; // RULE7
            end
            default: begin
                has_dest = 1'b0;
            end
        endcase
    end

    // ==================================================================
    // Next state
    // ==================================================================
    always_comb begin
        nxt_state = state_ff;
        nxt_state.wr_en = 1'b0;
        case (state_ff.state)
            JIO_ST_RUN: begin
                nxt_state.skipped = 1'b0;
                if (take) begin
                    nxt_state.pc = state_ff.pc + JIO_PC_STEP;
                    if (instr_op == JIO_OP_JUMP_ABSOLUTE) begin
                        // Upper bits come only from the latch, never from
                        // the old counter, so pages change on a jump.
                        nxt_state.pc[10:0] = instr_literal; // RULE1
                        nxt_state.pc[12:11] =
                            upper_jump_latch[JIO_LATCH_HI:JIO_LATCH_LO]; // RULE2
                        nxt_state.state = JIO_ST_DEAD; // RULE3
                        nxt_state.ready = 1'b0; // RULE3
                    end
                    if (has_dest && instr_dest != JIO_DEST_ACC) begin
                        nxt_state.wr_en = 1'b1; // RULE4
                        nxt_state.wr_addr = instr_reg_addr; // RULE4
                        nxt_state.wr_data = alu_bus.result; // RULE4
                    end else if (has_dest ||
                        instr_op == JIO_OP_OR_LITERAL_INTO_ACCUMULATOR) begin
                        nxt_state.acc = alu_bus.result; // RULE4
                    end
                    if (upd_zero) begin
                        nxt_state.zero = alu_bus.zero; // RULE9
                    end
                    if (instr_op == JIO_OP_INCREMENT_SKIP_ON_NULL &&
                        alu_bus.zero) begin
                        // Step over the next word and burn one cycle as
                        // the no-operation that replaces it.
                        nxt_state.pc = state_ff.pc + JIO_PC_SKIP; // RULE5
                        nxt_state.state = JIO_ST_DEAD; // RULE5
                        nxt_state.ready = 1'b0; // RULE5
                        nxt_state.skipped = 1'b1; // RULE5
                    end
                end
            end
            JIO_ST_DEAD: begin
                // The second cycle only waits; only the write strobe drops.
                nxt_state.state = JIO_ST_RUN;
                nxt_state.ready = 1'b1;
            end
            default: begin
                nxt_state.state = JIO_ST_RUN;
                nxt_state.ready = 1'b1;
            end
        endcase
    end

    // ==================================================================
    // State register
    // ==================================================================
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff.state <= JIO_ST_RUN;
            state_ff.ready <= 1'b1;
            state_ff.pc <= JIO_PC_RESET;
            state_ff.acc <= JIO_DATA_RESET;
            state_ff.zero <= 1'b0;
            state_ff.wr_en <= 1'b0;
            state_ff.wr_addr <= JIO_ADDR_RESET;
            state_ff.wr_data <= JIO_DATA_RESET;
            state_ff.skipped <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==================================================================
    // Outputs, all straight from the state register
    // ==================================================================
    assign instr_ready = state_ff.ready;
    assign program_counter = state_ff.pc;
    assign accumulator = state_ff.acc;
    assign zero_flag = state_ff.zero;
    assign reg_wr_en = state_ff.wr_en;
    assign reg_wr_addr = state_ff.wr_addr;
    assign reg_wr_data = state_ff.wr_data;
    assign skip_nop = state_ff.skipped;

    // ==================================================================
    // Assertions
    // ==================================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_jump_low_bits: assert property ( // RULE1
        take && instr_op == JIO_OP_JUMP_ABSOLUTE
        |=> program_counter[10:0] == $past(instr_literal))
        else $error("Jump did not load the low counter bits.");

    chk_jump_high_bits: assert property ( // RULE2
        take && instr_op == JIO_OP_JUMP_ABSOLUTE
        |=> program_counter[12:11] == $past(upper_jump_latch[4:3]))
        else $error("Jump did not copy the latch bits.");

    chk_jump_two_cycle: assert property ( // RULE3
        take && instr_op == JIO_OP_JUMP_ABSOLUTE
        |=> !instr_ready && $stable(zero_flag) && $stable(accumulator)
        ##1 instr_ready && $stable(program_counter))
        else $error("Jump timing or flags wrong.");

    chk_dest_register: assert property ( // RULE4
        take && instr_op == JIO_OP_INCREMENT_REGISTER && instr_dest
        |=> reg_wr_en && reg_wr_addr == $past(instr_reg_addr)
        && reg_wr_data == $past(reg_rdata) + 8'h01 && $stable(accumulator))
        else $error("Register destination not written.");

    chk_dest_accum: assert property ( // RULE4
        take && instr_op == JIO_OP_OR_ACCUMULATOR_WITH_REGISTER && !instr_dest
        |=> !reg_wr_en && accumulator == ($past(accumulator) | $past(reg_rdata)))
        else $error("Accumulator destination not written.");

    chk_skip_zero: assert property ( // RULE5
        take && instr_op == JIO_OP_INCREMENT_SKIP_ON_NULL && reg_rdata == 8'hff
        |=> program_counter == $past(program_counter) + 13'h0002
        && skip_nop && !instr_ready && $stable(zero_flag) ##1 instr_ready)
        else $error("Skip on zero result misbehaved.");

    chk_skip_nonzero: assert property ( // RULE5
        take && instr_op == JIO_OP_INCREMENT_SKIP_ON_NULL && reg_rdata != 8'hff
        |=> program_counter == $past(program_counter) + 13'h0001
        && instr_ready && $stable(zero_flag))
        else $error("Skip taken on nonzero result.");

    chk_inc_zero: assert property ( // RULE6
        take && instr_op == JIO_OP_INCREMENT_REGISTER
        |=> zero_flag == ($past(reg_rdata) == 8'hff))
        else $error("Increment zero flag wrong.");

    chk_or_literal: assert property ( // RULE7
        take && instr_op == JIO_OP_OR_LITERAL_INTO_ACCUMULATOR
        |=> accumulator == ($past(accumulator) | $past(instr_literal[7:0]))
        && zero_flag == (accumulator == 8'h00) && !reg_wr_en)
        else $error("Literal OR result wrong.");

    chk_or_reg_zero: assert property ( // RULE8
        take && instr_op == JIO_OP_OR_ACCUMULATOR_WITH_REGISTER && instr_dest
        |=> reg_wr_data == ($past(accumulator) | $past(reg_rdata))
        && zero_flag == (reg_wr_data == 8'h00))
        else $error("Register OR result wrong.");

    chk_zero_exact: assert property ( // RULE9
        take && upd_zero
        |=> zero_flag == (reg_wr_en ? reg_wr_data == 8'h00
                                    : accumulator == 8'h00))
        else $error("Zero flag does not match the stored result.");

    cov_jump: cover property (take && instr_op == JIO_OP_JUMP_ABSOLUTE);
    cov_skip: cover property (take && instr_op ==
        JIO_OP_INCREMENT_SKIP_ON_NULL ##1 skip_nop);
    cov_reg_write: cover property (reg_wr_en ##1 reg_wr_en);
    cov_zero_set: cover property ($rose(zero_flag));
endmodule // jio_top

// ### include/jio_pkg.sv
// Constants, enumerations and field positions for the jump, increment and
// OR execution block. Assumes one instruction clock shared by the core.
// Contract
// (RULE1) Jump loads literal into counter bits ten-zero.
// (RULE2) Jump copies latch bits four-three upward.
// (RULE3) Jump is unconditional, two cycles, flags kept.
// (RULE4) Destination bit picks accumulator or register.
// (RULE5) Increment-skip adds one; zero result skips next.
// (RULE6) Plain increment adds one, updates zero flag.
// (RULE7) OR literal into accumulator, update zero flag.
// (RULE8) OR accumulator with register, update zero flag.
// (RULE9) Zero flag set exactly when result is zero.
package jio_pkg;
    // ==================================================================
    // Widths and field positions
    // ==================================================================
    localparam int JIO_PC_W = 13;
    localparam int JIO_LIT_W = 11;
    localparam int JIO_DATA_W = 8;
    localparam int JIO_ADDR_W = 7;
    localparam int JIO_LATCH_HI = 4;
    localparam int JIO_LATCH_LO = 3;
    // Destination bit value that selects the accumulator.
    localparam logic JIO_DEST_ACC = 1'b0;
    // ==================================================================
    // Reset values and steps
    // ==================================================================
    localparam logic [12:0] JIO_PC_RESET = 13'h0000;
    localparam logic [12:0] JIO_PC_STEP = 13'h0001;
    localparam logic [12:0] JIO_PC_SKIP = 13'h0002;
    localparam logic [7:0] JIO_DATA_RESET = 8'h00;
    localparam logic [7:0] JIO_ONE = 8'h01;
    localparam logic [7:0] JIO_ZERO = 8'h00;
    localparam logic [6:0] JIO_ADDR_RESET = 7'h00;
    // ==================================================================
    // Operations and states
    // ==================================================================
    typedef enum logic [2:0] {
        JIO_OP_NOP = 3'b000,
        JIO_OP_JUMP_ABSOLUTE = 3'b001,
        JIO_OP_INCREMENT_SKIP_ON_NULL = 3'b010,
        JIO_OP_OR_LITERAL_INTO_ACCUMULATOR = 3'b011,
        JIO_OP_INCREMENT_REGISTER = 3'b100,
        JIO_OP_OR_ACCUMULATOR_WITH_REGISTER = 3'b101
    } jio_op_type;
    typedef enum logic [0:0] {
        JIO_ST_RUN = 1'b0,
        JIO_ST_DEAD = 1'b1
    } jio_state_type;
endpackage

// ### include/jio_alu_if.sv
// Interface between the execution control and its data path.
// Assumes both ends sit on the same instruction clock.
`timescale 1ns/1ps
interface jio_alu_if;
    import jio_pkg::*;
    jio_op_type op; // Operation to evaluate.
    logic [7:0] acc; // Current accumulator.
    logic [7:0] opnd; // Register operand value.
    logic [7:0] lit; // Eight-bit literal.
    logic [7:0] result; // Computed result.
    logic zero; // Result is all zeros.
    modport ctrl (output op, output acc, output opnd, output lit,
                  input result, input zero);
    modport alu (input op, input acc, input opnd, input lit,
                 output result, output zero);
endinterface

// ### rtl/jio_alu.sv
// Combinational data path: increment and inclusive OR with zero detect.
// Assumes operands are stable for the cycle in which they are used.
`timescale 1ns/1ps
module jio_alu
    import jio_pkg::*;
(
    jio_alu_if.alu bus
);
    // ==================================================================
    // Result selection
    // ==================================================================
    // Pure logic, so the control decides when the result counts.
    always_comb begin
        case (bus.op)
            JIO_OP_INCREMENT_SKIP_ON_NULL,
            JIO_OP_INCREMENT_REGISTER: begin
                // Wraps from all ones to zero, which drives the skip.
                bus.result = bus.opnd + JIO_ONE; // RULE5 RULE6
            end
            JIO_OP_OR_LITERAL_INTO_ACCUMULATOR: begin
                bus.result = bus.acc | bus.lit; // RULE7
            end
            JIO_OP_OR_ACCUMULATOR_WITH_REGISTER: begin
                bus.result = bus.acc | bus.opnd; // RULE8
            end
            default: begin
                bus.result = JIO_ZERO;
            end
        endcase
        // Full eight-bit compare; no carry or partial bits count.
        bus.zero = (bus.result == JIO_ZERO); // RULE9
    end
endmodule // jio_alu

// ### dv/jio_regfile_model.sv
// Behavioural file registers that face the execution block.
// Assumes one instruction clock; reads are combinational, writes clocked.
`timescale 1ns/1ps
module jio_regfile_model (
    input wire logic ref_clk,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data
);
    // ==================================================================
    // Storage
    // ==================================================================
    logic [7:0] mem [0:127]; // File registers, also preloaded by the bench.
    // Start from zeros so that an idle read never feeds unknowns inward.
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // Reads answer at once, as the execution block expects.
    assign rd_data = mem[rd_addr];
    // A write lands on the edge that carries the write pulse.
    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule // jio_regfile_model

// ### dv/jump_increment_or_execute_tb.sv
// Self-checking bench for the jump, increment and OR execution block.
// Assumes the package is compiled first and the block asserts itself.
`timescale 1ns/1ps
module jump_increment_or_execute_tb;
    import jio_pkg::*;
    // ==================================================================
    // Stimulus, outputs and bench state
    // ==================================================================
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    jio_op_type instr_op = JIO_OP_NOP;
    logic [10:0] instr_literal = 11'h000;
    logic [6:0] instr_reg_addr = 7'h00;
    logic instr_dest = 1'b0;
    logic [7:0] upper_jump_latch = 8'h00;
    logic [7:0] reg_rdata;
    logic instr_ready;
    logic [12:0] program_counter;
    logic [7:0] accumulator;
    logic zero_flag;
    logic reg_wr_en;
    logic [6:0] reg_wr_addr;
    logic [7:0] reg_wr_data;
    logic skip_nop;
    logic [12:0] m_pc = 13'h0000; // Expected counter, starts at reset value.
    logic [7:0] m_acc = 8'h00; // Expected accumulator.
    logic m_z = 1'b0; // Expected zero flag.
    int err_total = 0;
    int n_compared = 0;
    // The clock toggles every half period of 10 ns.
    always #5 ref_clk = ~ref_clk;
    jio_top u_dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_literal(instr_literal),
        .instr_reg_addr(instr_reg_addr), .instr_dest(instr_dest),
        .reg_rdata(reg_rdata), .upper_jump_latch(upper_jump_latch),
        .instr_ready(instr_ready), .program_counter(program_counter),
        .accumulator(accumulator), .zero_flag(zero_flag),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .skip_nop(skip_nop));
    jio_regfile_model u_rf (.ref_clk(ref_clk), .rd_addr(instr_reg_addr),
        .rd_data(reg_rdata), .wr_en(reg_wr_en), .wr_addr(reg_wr_addr),
        .wr_data(reg_wr_data));
    // ==================================================================
    // Shared tasks
    // ==================================================================
    // Compare as four-state, so an unknown never passes.
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Print the counts and the verdict, then stop.
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Offer one instruction, hold it until taken, then judge every output.
    // Valid drops on the taking edge, so each call is taken exactly once.
    task automatic issue(jio_op_type op, logic [10:0] lit, logic [6:0] a,
                         logic d, logic [7:0] v);
        logic [7:0] r;
        logic wr;
        logic skip;
        logic jmp;
        int n;
        @(posedge ref_clk);
        u_rf.mem[a] <= v;
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_literal <= lit;
        instr_reg_addr <= a;
        instr_dest <= d;
        n = 0;
        @(negedge ref_clk);
        while (instr_ready !== 1'b1 && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 8) begin
            err_total++;
            test_done();
        end
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
        jmp = (op == JIO_OP_JUMP_ABSOLUTE);
        if (op == JIO_OP_OR_LITERAL_INTO_ACCUMULATOR) r = m_acc | lit[7:0];
        else if (op == JIO_OP_OR_ACCUMULATOR_WITH_REGISTER) r = m_acc | v;
        else r = v + 8'h01;
        wr = d && (op == JIO_OP_INCREMENT_SKIP_ON_NULL ||
            op == JIO_OP_INCREMENT_REGISTER ||
            op == JIO_OP_OR_ACCUMULATOR_WITH_REGISTER);
        skip = (op == JIO_OP_INCREMENT_SKIP_ON_NULL) && (r == 8'h00);
        if (jmp) m_pc = {upper_jump_latch[4:3], lit};
        else m_pc = m_pc + (skip ? 13'h0002 : 13'h0001);
        if (!jmp && op != JIO_OP_NOP && !wr) m_acc = r;
        if (op == JIO_OP_OR_LITERAL_INTO_ACCUMULATOR ||
            op == JIO_OP_INCREMENT_REGISTER ||
            op == JIO_OP_OR_ACCUMULATOR_WITH_REGISTER) m_z = (r == 8'h00);
        check("program_counter", 16'(program_counter), 16'(m_pc));
        check("accumulator", 16'(accumulator), 16'(m_acc));
        check("zero_flag", 16'(zero_flag), 16'(m_z));
        check("reg_wr_en", 16'(reg_wr_en), 16'(wr));
        if (wr) check("reg_wr", 16'({reg_wr_addr, reg_wr_data}), 16'({a, r}));
        check("skip_nop", 16'(skip_nop), 16'(skip));
        check("instr_ready", 16'(instr_ready), 16'(!(jmp || skip)));
    endtask
    // ==================================================================
    // Scenarios
    // ==================================================================
    // Outputs right after reset match the documented reset state.
    task automatic t_reset();
        @(negedge ref_clk);
        check("reset_state", {program_counter, zero_flag, reg_wr_en, skip_nop},
            16'h0000);
        check("reset_acc", 16'({instr_ready, accumulator}), 16'h0100);
        $display("test reset done");
    endtask
    // Jumps to both counter edges and one inner address, with the flag set beforehand.
    task automatic t_jump();
        logic [7:0] latch [3] = '{8'h18, 8'he7, 8'h08};
        logic [10:0] tgt [3] = '{11'h7ff, 11'h000, 11'h123};
        issue(JIO_OP_OR_LITERAL_INTO_ACCUMULATOR, 11'h000, 7'h00, 1'b0, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            upper_jump_latch <= latch[i];
            issue(JIO_OP_JUMP_ABSOLUTE, tgt[i], 7'h00, 1'b0, 8'h00);
        end
        $display("test jump done");
    endtask
    // Plain increment to both destinations, wrapping to zero once.
    task automatic t_inc();
        issue(JIO_OP_INCREMENT_REGISTER, 11'h000, 7'h05, 1'b0, 8'hff);
        issue(JIO_OP_INCREMENT_REGISTER, 11'h000, 7'h7f, 1'b1, 8'h41);
        issue(JIO_OP_INCREMENT_REGISTER, 11'h000, 7'h00, 1'b1, 8'hfe);
        $display("test inc done");
    endtask
    // Skip taken and not taken, then a plain no-operation.
    task automatic t_skip();
        issue(JIO_OP_INCREMENT_SKIP_ON_NULL, 11'h000, 7'h12, 1'b1, 8'hff);
        issue(JIO_OP_INCREMENT_SKIP_ON_NULL, 11'h000, 7'h13, 1'b0, 8'h10);
        issue(JIO_OP_INCREMENT_SKIP_ON_NULL, 11'h000, 7'h33, 1'b0, 8'hff);
        issue(JIO_OP_NOP, 11'h000, 7'h00, 1'b0, 8'h00);
        $display("test skip done");
    endtask
    // OR forms, with a zero result from the register form at the end.
    task automatic t_or();
        issue(JIO_OP_OR_LITERAL_INTO_ACCUMULATOR, 11'h780, 7'h00, 1'b1, 8'h00);
        issue(JIO_OP_OR_ACCUMULATOR_WITH_REGISTER, 11'h000, 7'h7f, 1'b1, 8'h01);
        issue(JIO_OP_OR_ACCUMULATOR_WITH_REGISTER, 11'h000, 7'h01, 1'b0, 8'h00);
        issue(JIO_OP_INCREMENT_SKIP_ON_NULL, 11'h000, 7'h02, 1'b0, 8'hff);
        issue(JIO_OP_OR_ACCUMULATOR_WITH_REGISTER, 11'h000, 7'h03, 1'b0, 8'h00);
        $display("test or done");
    endtask
    // A second offer held through the dead cycle of a jump is refused
    // there and taken once ready returns; the accumulator proves it.
    task automatic t_refuse();
        int n;
        @(posedge ref_clk);
        upper_jump_latch <= 8'h10;
        instr_valid <= 1'b1;
        instr_op <= JIO_OP_JUMP_ABSOLUTE;
        instr_literal <= 11'h456;
        n = 0;
        @(negedge ref_clk);
        while (instr_ready !== 1'b1 && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 8) begin
            err_total++;
            test_done();
        end
        // The jump is taken here; the next offer replaces it at once.
        @(posedge ref_clk);
        instr_op <= JIO_OP_OR_LITERAL_INTO_ACCUMULATOR;
        instr_literal <= 11'h0ff;
        m_pc = {2'b10, 11'h456};
        @(negedge ref_clk);
        check("refuse_pc", 16'(program_counter), 16'(m_pc));
        check("refuse_busy", 16'(instr_ready), 16'h0000);
        // The dead edge passes with valid high and must change nothing.
        @(negedge ref_clk);
        check("refuse_idle", 16'(instr_ready), 16'h0001);
        check("refuse_hold_pc", 16'(program_counter), 16'(m_pc));
        check("refuse_hold_acc", 16'(accumulator), 16'(m_acc));
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        m_pc = m_pc + 13'h0001;
        m_acc = m_acc | 8'hff;
        m_z = 1'b0;
        @(negedge ref_clk);
        check("refuse_take_pc", 16'(program_counter), 16'(m_pc));
        check("refuse_take_acc", 16'(accumulator), 16'(m_acc));
        check("refuse_take_z", 16'(zero_flag), 16'(m_z));
        $display("test refuse done");
    endtask
    // Reset in mid-run returns every output to its reset value.
    task automatic t_reset_mid();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        m_pc = 13'h0000;
        m_acc = 8'h00;
        m_z = 1'b0;
        t_reset();
    endtask
    // Main sequence: four cycles of reset, then every scenario in turn.
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_jump();
        t_inc();
        t_skip();
        t_or();
        t_refuse();
        t_reset_mid();
        t_inc();
        test_done();
    end
endmodule // jump_increment_or_execute_tb
